// ### serial_bus_pkg.sv
// package: register map, timing counts and state carrier for the two-wire slave block
package serial_bus_pkg;
    // word offsets on the register bus
    localparam logic [3:0] OFS_CTRL_ONE  = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO  = 4'h4;   // write: control, read: status
    localparam logic [3:0] OFS_DATA_BUF  = 4'h8;
    localparam logic [3:0] OFS_OWN_ADDR  = 4'hc;
    // field positions in serial_ctrl_one
    localparam int BIT_COUNT_LSB = 5;
    localparam int ACK_MODE_BIT  = 4;
    // field positions in serial_ctrl_two / serial_status_reg
    localparam int MST_BIT  = 7;
    localparam int TRX_BIT  = 6;
    localparam int BB_BIT   = 5;
    localparam int PIN_BIT  = 4;
    localparam int AL_BIT   = 3;
    localparam int AAS_BIT  = 2;
    localparam int AD0_BIT  = 1;
    localparam int LRB_BIT  = 0;
    // reset values
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    // timing
    localparam int CLK_NS     = 10;
    localparam int T_LOW_NS   = 4700;
    localparam int T_SU_STO_NS = 4000;
    localparam logic [9:0] LOW_CYC = 10'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] SU_CYC  = 10'((T_SU_STO_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SHIFT = 3'b001,
        ST_ACKB  = 3'b010,
        ST_HOLD  = 3'b011,
        ST_STOPA = 3'b100,
        ST_STOPB = 3'b101
    } phase_t;

    typedef struct packed {
        logic        wbAck;
        logic [31:0] wbDat;
        logic        sclMeta, sclSync, sclPrev;
        logic        sdaMeta, sdaSync, sdaPrev;
        logic        master_select, trx, bb, pin, al, aas, ad0, lrb;
        logic [2:0]  bitCount;
        logic        ackMode;
        logic [6:0]  ownAddr;
        logic [7:0]  txWord, rxWord, shiftReg;
        logic [3:0]  cnt;
        logic        addrPhase, txActive, lostNow;
        phase_t      phase;
        logic [9:0]  timer;
        logic        sclOe, sdaOe, irq;
    } state_t;
endpackage

// ### serial_bus_slave.sv
// two-wire bus slave engine with stop generation, bus release and wishbone registers
`timescale 1ns/1ps
module serial_bus_slave (
    // system
    input  wire logic        clk,
    input  wire logic        reset,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // two-wire bus pins
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // event to the cpu
    output logic             serial_bus_irq
);
    serial_bus_pkg::state_t s_ff, nxt_s;
    logic access, wrCtrlTwo, stopCmd, relCmd, sclRise, sclFall, startSeen, stopSeen;
    logic match, genCall;
    logic [3:0] wordLen;

    function automatic logic [7:0] statusByte(input serial_bus_pkg::state_t s);
        statusByte = {s.master_select, s.trx, s.bb, s.pin, s.al, s.aas, s.ad0, s.lrb};
    endfunction

    always_comb begin
        nxt_s = s_ff;
        // synchronisers: the first stage feeds no logic; the second and third stages feed the edge and condition detectors
        nxt_s.sclMeta = sclIn;
        nxt_s.sclSync = s_ff.sclMeta;
        nxt_s.sclPrev = s_ff.sclSync;
        nxt_s.sdaMeta = sdaIn;
        nxt_s.sdaSync = s_ff.sdaMeta;
        nxt_s.sdaPrev = s_ff.sdaSync;
        sclRise   = s_ff.sclSync & ~s_ff.sclPrev;
        sclFall   = ~s_ff.sclSync & s_ff.sclPrev;
        startSeen = s_ff.sclSync & s_ff.sclPrev & s_ff.sdaPrev & ~s_ff.sdaSync;
        stopSeen  = s_ff.sclSync & s_ff.sclPrev & ~s_ff.sdaPrev & s_ff.sdaSync;
        wordLen   = (s_ff.addrPhase || s_ff.bitCount == 3'h0) ? 4'h8 : {1'b0, s_ff.bitCount};
        match     = s_ff.rxWord[7:1] == s_ff.ownAddr;
        genCall   = s_ff.rxWord == 8'h00;
        nxt_s.irq = ~s_ff.pin;

        // register bus: one wait state, ack drops the cycle after
        access    = wb_cyc_i & wb_stb_i & ~s_ff.wbAck;
        nxt_s.wbAck = access;
        wrCtrlTwo = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == serial_bus_pkg::OFS_CTRL_TWO);
        stopCmd   = wrCtrlTwo & s_ff.bb & (wb_dat_i[7:4] == 4'hd);
        relCmd    = wrCtrlTwo & s_ff.master_select & (wb_dat_i[7:4] == 4'h1);
        if (access) begin
            unique case (wb_adr_i)
                serial_bus_pkg::OFS_CTRL_ONE: nxt_s.wbDat = {24'h0, s_ff.bitCount,
                                                             s_ff.ackMode, 4'h0};
                serial_bus_pkg::OFS_CTRL_TWO: nxt_s.wbDat = {24'h0, statusByte(s_ff)};
                serial_bus_pkg::OFS_DATA_BUF: nxt_s.wbDat = {24'h0, s_ff.rxWord};
                serial_bus_pkg::OFS_OWN_ADDR: nxt_s.wbDat = {25'h0, s_ff.ownAddr};
                default:                      nxt_s.wbDat = 32'h0;
            endcase
            if (wb_adr_i == serial_bus_pkg::OFS_DATA_BUF && (~wb_we_i | wb_sel_i[0]))
                nxt_s.pin = 1'b1;
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    serial_bus_pkg::OFS_CTRL_ONE: begin
                        nxt_s.bitCount = wb_dat_i[serial_bus_pkg::BIT_COUNT_LSB +: 3];
                        nxt_s.ackMode  = wb_dat_i[serial_bus_pkg::ACK_MODE_BIT];
                    end
                    serial_bus_pkg::OFS_CTRL_TWO: begin
                        nxt_s.master_select = wb_dat_i[serial_bus_pkg::MST_BIT];
                        nxt_s.trx = wb_dat_i[serial_bus_pkg::TRX_BIT];
                        if (wb_dat_i[serial_bus_pkg::PIN_BIT])
                            nxt_s.pin = 1'b1;
                    end
                    serial_bus_pkg::OFS_DATA_BUF: nxt_s.txWord = wb_dat_i[7:0];
                    serial_bus_pkg::OFS_OWN_ADDR: nxt_s.ownAddr = wb_dat_i[6:0];
                    default: ;
                endcase
            end
        end

        // bus engine
        unique case (s_ff.phase)
            serial_bus_pkg::ST_IDLE: ;
            serial_bus_pkg::ST_SHIFT: begin
                if (sclRise) begin
                    nxt_s.shiftReg = {s_ff.shiftReg[6:0], s_ff.sdaSync};
                    nxt_s.cnt      = s_ff.cnt + 4'h1;
                    // drove a one, saw a zero: another master wins
                    if (s_ff.txActive && s_ff.master_select && s_ff.shiftReg[7] && !s_ff.sdaSync) begin
                        nxt_s.al       = 1'b1;
                        nxt_s.master_select      = 1'b0;
                        nxt_s.txActive = 1'b0;
                        nxt_s.lostNow  = 1'b1;
                    end
                end else if (sclFall) begin
                    if (s_ff.cnt == wordLen) begin
                        nxt_s.rxWord = s_ff.shiftReg;
                        nxt_s.phase  = serial_bus_pkg::ST_ACKB;
                        if (s_ff.addrPhase && !s_ff.master_select) begin
                            if (s_ff.shiftReg[7:1] == s_ff.ownAddr || s_ff.shiftReg == 8'h00)
                                nxt_s.sdaOe = 1'b1;
                            else if (!s_ff.lostNow) begin
                                nxt_s.sdaOe = 1'b0;
                                nxt_s.phase = serial_bus_pkg::ST_IDLE;
                            end else
                                nxt_s.sdaOe = 1'b0;
                        end else
                            nxt_s.sdaOe = ~s_ff.txActive & s_ff.ackMode & ~s_ff.addrPhase;
                    end else
                        nxt_s.sdaOe = s_ff.txActive & ~s_ff.shiftReg[7];
                end
            end
            serial_bus_pkg::ST_ACKB: begin
                if (sclRise)
                    nxt_s.lrb = s_ff.sdaSync;
                else if (sclFall) begin
                    nxt_s.sdaOe = 1'b0;
                    nxt_s.pin   = 1'b0;
                    nxt_s.sclOe = 1'b1;
                    nxt_s.timer = 10'h0;
                    nxt_s.phase = serial_bus_pkg::ST_HOLD;
                    if (s_ff.addrPhase && !s_ff.master_select) begin
                        if (match || genCall) begin
                            nxt_s.aas = 1'b1;
                            nxt_s.ad0 = genCall;
                            nxt_s.trx = s_ff.rxWord[0];
                        end else begin
                            nxt_s.trx = 1'b0;
                            nxt_s.aas = 1'b0;
                            nxt_s.ad0 = 1'b0;
                        end
                    end else if (!s_ff.addrPhase) begin
                        nxt_s.aas = 1'b0;
                        if (s_ff.lostNow) begin
                            nxt_s.trx = 1'b0;
                            nxt_s.ad0 = 1'b0;
                        end else if (s_ff.txActive) begin
                            nxt_s.trx = 1'b1;
                            nxt_s.al  = 1'b0;
                            nxt_s.ad0 = 1'b0;
                        end else begin
                            nxt_s.trx = 1'b0;
                            nxt_s.al  = 1'b0;
                        end
                    end
                end
            end
            serial_bus_pkg::ST_HOLD: begin
                // release only after a full low period once serviced
                if (s_ff.pin) begin
                    if (s_ff.timer < serial_bus_pkg::LOW_CYC - 10'h1)
                        nxt_s.timer = s_ff.timer + 10'h1;
                    else begin
                        nxt_s.sclOe     = 1'b0;
                        nxt_s.cnt       = 4'h0;
                        nxt_s.addrPhase = 1'b0;
                        nxt_s.lostNow   = 1'b0;
                        nxt_s.shiftReg  = s_ff.txWord;
                        nxt_s.txActive  = s_ff.trx;
                        nxt_s.sdaOe     = s_ff.trx & ~s_ff.txWord[7];
                        nxt_s.phase     = serial_bus_pkg::ST_SHIFT;
                    end
                end
            end
            serial_bus_pkg::ST_STOPA: begin
                // sda low under a held clock, then wait for every holder of scl
                nxt_s.sdaOe = 1'b1;
                if (s_ff.timer < serial_bus_pkg::LOW_CYC) begin
                    nxt_s.timer = s_ff.timer + 10'h1;
                    nxt_s.sclOe = 1'b1;
                end else begin
                    nxt_s.sclOe = 1'b0;
                    if (s_ff.sclSync) begin
                        nxt_s.timer = 10'h0;
                        nxt_s.phase = serial_bus_pkg::ST_STOPB;
                    end
                end
            end
            serial_bus_pkg::ST_STOPB: begin
                if (s_ff.timer < serial_bus_pkg::SU_CYC)
                    nxt_s.timer = s_ff.timer + 10'h1;
                else begin
                    nxt_s.sdaOe = 1'b0;
                    nxt_s.phase = serial_bus_pkg::ST_IDLE;
                end
            end
            default: nxt_s.phase = serial_bus_pkg::ST_IDLE;
        endcase

        // bus conditions seen on the wires override the engine, except a start seen while in ST_STOPA
        if (startSeen && s_ff.phase != serial_bus_pkg::ST_STOPA) begin
            nxt_s.bb        = 1'b1;
            nxt_s.phase     = serial_bus_pkg::ST_SHIFT;
            nxt_s.cnt       = 4'h0;
            nxt_s.addrPhase = 1'b1;
            nxt_s.lostNow   = 1'b0;
            nxt_s.al        = 1'b0;
            nxt_s.aas       = 1'b0;
            nxt_s.ad0       = 1'b0;
            nxt_s.shiftReg  = s_ff.txWord;
            nxt_s.txActive  = s_ff.master_select & s_ff.trx;
        end
        if (stopSeen) begin
            nxt_s.bb    = 1'b0;
            nxt_s.master_select   = 1'b0;
            nxt_s.trx   = 1'b0;
            nxt_s.aas   = 1'b0;
            nxt_s.sclOe = 1'b0;
            nxt_s.sdaOe = 1'b0;
            nxt_s.phase = serial_bus_pkg::ST_IDLE;
        end
        if (stopCmd) begin
            nxt_s.timer = 10'h0;
            nxt_s.phase = serial_bus_pkg::ST_STOPA;
        end else if (relCmd) begin
            // no stop on the wires, so the bus still looks busy to others
            nxt_s.sclOe = 1'b0;
            nxt_s.sdaOe = 1'b0;
            nxt_s.phase = serial_bus_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_ff          <= '0;
            s_ff.pin      <= 1'b1;
            s_ff.sclSync  <= 1'b1;
            s_ff.sclPrev  <= 1'b1;
            s_ff.sdaSync  <= 1'b1;
            s_ff.sdaPrev  <= 1'b1;
            s_ff.lrb      <= 1'b1;
            s_ff.bitCount <= serial_bus_pkg::BIT_COUNT_RESET;
            s_ff.ownAddr  <= serial_bus_pkg::OWN_ADDR_RESET;
            s_ff.phase    <= serial_bus_pkg::ST_IDLE;
        end else
            s_ff <= nxt_s;
    end

    assign wb_dat_o       = s_ff.wbDat;
    assign wb_ack_o       = s_ff.wbAck;
    assign sclOut         = 1'b0;
    assign sdaOut         = 1'b0;
    assign sclOe          = s_ff.sclOe;
    assign sdaOe          = s_ff.sdaOe;
    assign serial_bus_irq = s_ff.irq;

    AST_EVENT_HOLDS_SCL: assert property (@(posedge clk) disable iff (reset)
        $fell(s_ff.pin) |-> s_ff.sclOe && !s_ff.irq ##1 s_ff.irq)
        else $error("event did not hold scl and raise irq");
    AST_STATUS_BEFORE_IRQ: assert property (@(posedge clk) disable iff (reset)
        $rose(serial_bus_irq) |-> $stable(statusByte(s_ff) & 8'h4e))
        else $error("status changed as irq rose");
    AST_LOST_READ_ADDR: assert property (@(posedge clk) disable iff (reset)
        $fell(s_ff.pin) && s_ff.al && s_ff.aas && s_ff.trx |-> !s_ff.ad0)
        else $error("lost read address shows general call");
    AST_TX_WORD_DONE: assert property (@(posedge clk) disable iff (reset)
        $fell(s_ff.pin) && $past(s_ff.txActive) && !$past(s_ff.addrPhase) && !$past(s_ff.lostNow)
        |-> s_ff.trx && !s_ff.al && !s_ff.aas && !s_ff.ad0)
        else $error("wrong status after transmitted word");
    AST_LOST_UNADDR: assert property (@(posedge clk) disable iff (reset)
        $fell(s_ff.pin) && s_ff.al && !s_ff.aas |-> !s_ff.trx && !s_ff.ad0)
        else $error("wrong status after lost word");
    AST_RX_WORD_DONE: assert property (@(posedge clk) disable iff (reset)
        $fell(s_ff.pin) && !$past(s_ff.txActive) && !$past(s_ff.addrPhase)
        && !$past(s_ff.lostNow) |-> !s_ff.trx && !s_ff.al && !s_ff.aas)
        else $error("wrong status after received word");
    AST_LOW_PERIOD: assert property (@(posedge clk) disable iff (reset)
        s_ff.phase == serial_bus_pkg::ST_HOLD && $rose(s_ff.pin) |-> s_ff.sclOe [*8])
        else $error("scl released before low period");
    AST_STOP_START: assert property (@(posedge clk) disable iff (reset)
        stopCmd |=> s_ff.phase == serial_bus_pkg::ST_STOPA ##1 s_ff.sdaOe)
        else $error("stop request not started");
    AST_STOP_WAITS_SCL: assert property (@(posedge clk) disable iff (reset)
        s_ff.phase == serial_bus_pkg::ST_STOPA && !s_ff.sclSync && !stopCmd |=> s_ff.sdaOe)
        else $error("sda rose while scl held low");
    AST_RELEASE_BUS: assert property (@(posedge clk) disable iff (reset)
        relCmd && !stopSeen |=> !s_ff.sclOe && !s_ff.sdaOe
        && s_ff.phase == serial_bus_pkg::ST_IDLE)
        else $error("bus not released");
endmodule

// ### bus_peer.sv
// behavioural second party on the two-wire bus: start, stop and byte transfers
`timescale 1ns/1ps
module bus_peer (
    // system
    input  wire logic clk,
    // resolved wire levels and own pull-downs
    input  wire logic scl,
    input  wire logic sda,
    output logic      sclLow,
    output logic      sdaLow,
    output logic      stuck
);
    localparam int HALF = 8;
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        stuck = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // the slave may stretch scl, so the wire decides when high starts
    task automatic rise();
        int i;
        sclLow <= 1'b0;
        for (i = 0; i < 20000 && (i < 3 || scl !== 1'b1); i++) tick(1);
        if (scl !== 1'b1) stuck <= 1'b1;
        tick(HALF);
    endtask
    task automatic bit_out(input logic b);
        tick(2);
        sdaLow <= ~b;
        tick(HALF);
        rise();
        sclLow <= 1'b1;
    endtask
    task automatic bit_in(output logic b);
        tick(2);
        sdaLow <= 1'b0;
        tick(HALF);
        rise();
        b = sda;
        sclLow <= 1'b1;
    endtask
    task automatic start_cond();
        sdaLow <= 1'b1;
        tick(HALF);
        sclLow <= 1'b1;
    endtask
    task automatic stop_cond();
        tick(2);
        sdaLow <= 1'b1;
        tick(HALF);
        rise();
        sdaLow <= 1'b0;
        tick(HALF);
    endtask
    // msb first, ninth clock carries the acknowledge
    task automatic send(input logic [7:0] v, output logic ack);
        for (int k = 7; k >= 0; k--) bit_out(v[k]);
        bit_in(ack);
    endtask
    task automatic fetch(input logic nack, output logic [7:0] v);
        for (int k = 7; k >= 0; k--) bit_in(v[k]);
        bit_out(nack);
    endtask
    task automatic let_go();
        sclLow <= 1'b0;
    endtask
endmodule

// ### i2c_slave_stop_restart_bench.sv
// self-checking bench: software on wishbone and a second master on the wire
`timescale 1ns/1ps
module i2c_slave_stop_restart_bench;
    localparam logic [3:0] C1 = serial_bus_pkg::OFS_CTRL_ONE;
    localparam logic [3:0] C2 = serial_bus_pkg::OFS_CTRL_TWO;
    localparam logic [3:0] DB = serial_bus_pkg::OFS_DATA_BUF;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h1;
    logic [31:0] datIn = 32'h0;
    logic [31:0] datOut;
    logic        wbAck, sclOut, sclOe, sdaOut, sdaOe, irq, mScl, mSda, stuck;
    logic [31:0] seed = 32'h3c;
    int          error_cnt = 0;
    int          checks = 0;
    // open-drain wires with pull-ups
    wire scl = !(sclOe || mScl);
    wire sda = !(sdaOe || mSda);
    always #5 clk = ~clk;
    serial_bus_slave u_serial_bus_slave (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datIn),
        .wb_dat_o(datOut), .wb_ack_o(wbAck), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .serial_bus_irq(irq));
    bus_peer u_bus_peer (.clk(clk), .scl(scl), .sda(sda), .sclLow(mScl), .sdaLow(mSda),
        .stuck(stuck));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // expected status byte; lrb is masked by callers where it is not defined
    function automatic logic [7:0] st(input logic trx, bb, pin, aas, ad0);
        logic [7:0] s;
        s = 8'h00;
        s[serial_bus_pkg::TRX_BIT] = trx;
        s[serial_bus_pkg::BB_BIT] = bb;
        s[serial_bus_pkg::PIN_BIT] = pin;
        s[serial_bus_pkg::AAS_BIT] = aas;
        s[serial_bus_pkg::AD0_BIT] = ad0;
        return s;
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp, mask, input string what);
        checks++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic ran_out();
        error_cnt++;
        $display("Error t=%0t wait ran out", $time);
        report_and_stop();
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datIn <= {24'h0, d};
        for (i = 0; i < 50 && (i == 0 || wbAck !== 1'b1); i++) @(posedge clk);
        if (wbAck !== 1'b1) ran_out();
        q = datOut[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic wait_irq();
        int i;
        for (i = 0; i < 30000 && irq !== 1'b1; i++) @(posedge clk);
        if (irq !== 1'b1) ran_out();
        chk({7'h0, sclOe}, 8'h01, 8'hff, "scl held at event");
    endtask
    // after service the line stays low for the low period, then is let go
    task automatic low_period();
        int n;
        for (n = 0; n < 2000 && sclOe === 1'b1; n++) @(posedge clk);
        chk(8'(n >= 469 && n <= 480), 8'h01, 8'hff, "low period");
    endtask
    initial begin
        logic [7:0] q, own, d0, d1;
        logic ack;
        int n;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(0, 0, 1, 0, 0) | 8'h01, 8'hff, "status reset");
        wb(1'b0, 4'h2, 8'h00, q);
        chk(q, 8'h00, 8'hff, "unmapped");
        own = 8'h01 + (rnd() % 8'd126);
        wr(serial_bus_pkg::OFS_OWN_ADDR, own);
        wr(C1, 8'h10);
        // own address, then general call, each with one data word
        for (int g = 0; g < 2; g++) begin
            d0 = rnd();
            u_bus_peer.start_cond();
            u_bus_peer.send(g ? 8'h00 : {own[6:0], 1'b0}, ack);
            chk({7'h0, ack}, 8'h00, 8'hff, "address ack");
            wait_irq();
            wb(1'b0, C2, 8'h00, q);
            chk(q, st(0, 1, 0, 1, g[0]), 8'hfe, "write match");
            wb(1'b0, DB, 8'h00, q);
            low_period();
            u_bus_peer.send(d0, ack);
            wait_irq();
            wb(1'b0, C2, 8'h00, q);
            chk(q, st(0, 1, 0, 0, g[0]), 8'hfe, "rx word");
            wr(C1, 8'h10);
            wb(1'b0, DB, 8'h00, q);
            chk(q, d0, 8'hff, "rx data");
            u_bus_peer.stop_cond();
        end
        // read direction: one word acknowledged, the last one not
        d0 = rnd();
        d1 = rnd();
        u_bus_peer.start_cond();
        u_bus_peer.send({own[6:0], 1'b1}, ack);
        wait_irq();
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(1, 1, 0, 1, 0), 8'hfe, "read match");
        wr(C1, 8'h10);
        wr(DB, d0);
        u_bus_peer.fetch(1'b0, q);
        chk(q, d0, 8'hff, "tx word");
        wait_irq();
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(1, 1, 0, 0, 0), 8'hff, "tx acked");
        wr(C1, 8'h10);
        wr(DB, d1);
        u_bus_peer.fetch(1'b1, q);
        chk(q, d1, 8'hff, "tx last word");
        wait_irq();
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(1, 1, 0, 0, 0) | 8'h01, 8'hff, "tx not acked");
        wr(C2, 8'h50);
        wr(C2, 8'h10);
        u_bus_peer.stop_cond();
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(0, 0, 1, 0, 0), 8'hfe, "bus free");
        // stop request while the other party keeps scl low
        u_bus_peer.start_cond();
        u_bus_peer.send({~own[6:0], 1'b0}, ack);
        chk({7'h0, ack}, 8'h01, 8'hff, "foreign address");
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(0, 1, 1, 0, 0), 8'hfe, "busy");
        // take mastership, then let go without a stop: the bus stays busy
        wr(C2, 8'h80);
        wr(C2, 8'h10);
        chk({6'h0, sclOe, sdaOe}, 8'h00, 8'hff, "release");
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(0, 1, 1, 0, 0), 8'hfe, "released");
        wr(C2, 8'hd0);
        repeat (1000) @(posedge clk);
        chk({6'h0, sclOe, sdaOe}, 8'h01, 8'hff, "stop waits for scl");
        u_bus_peer.let_go();
        for (n = 0; n < 2000 && sdaOe === 1'b1; n++) @(posedge clk);
        chk({6'h0, scl, sdaOe}, 8'h02, 8'hff, "sda rises with scl high");
        chk(8'(n >= 400), 8'h01, 8'hff, "stop setup");
        repeat (5) @(posedge clk);
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(0, 0, 1, 0, 0), 8'hfe, "stopped");
        chk({7'h0, stuck}, 8'h00, 8'hff, "peer waits");
        // restart request once the bus is known free and the setup time has passed
        repeat (470) @(posedge clk);
        wr(C1, 8'h10);
        wr(DB, {own[6:0], 1'b0});
        wr(C2, 8'hf0);
        wb(1'b0, C2, 8'h00, q);
        chk(q, st(1, 0, 1, 0, 0) | 8'h80, 8'hfe, "restart request");
        report_and_stop();
    end
endmodule
